/* File: shared/bmx_params.svh */
`ifndef BMX_PARAMS_SVH
`define BMX_PARAMS_SVH
// ************************************************************
// opcodes, accumulator address, reset pc and lengths
// ************************************************************
`define BMX_OP_INC_A      8'h04
`define BMX_OP_INC_DIR    8'h05
`define BMX_OP_INC_IND    7'h03
`define BMX_OP_INC_RN     5'h01
`define BMX_OP_BR_CSET    8'h40
`define BMX_OP_BR_CCLR    8'h50
`define BMX_OP_BR_ANZ     8'h70
`define BMX_OP_BR_AZ      8'h60
`define BMX_OP_BR_BCLR    8'h30
`define BMX_OP_LJUMP      8'h02
`define BMX_OP_MV_A_RN    5'h1D
`define BMX_OP_MV_A_DIR   8'hE5
`define BMX_OP_MV_A_IND   7'h73
`define BMX_OP_MV_A_IMM   8'h74
`define BMX_OP_MV_RN_A    5'h1F
`define BMX_OP_MV_RN_DIR  5'h15
`define BMX_OP_MV_RN_IMM  5'h0F
`define BMX_OP_MV_DIR_A   8'hF5
`define BMX_OP_MV_DIR_RN  5'h11
`define BMX_OP_MV_DIR_DIR 8'h85
`define BMX_OP_MV_DIR_IND 7'h43
`define BMX_OP_MV_DIR_IMM 8'h75
`define BMX_OP_MV_IND_A   7'h7B
`define BMX_OP_MV_IND_DIR 7'h53
`define BMX_OP_MV_IND_IMM 7'h3B
`define BMX_ACC_ADDR      8'hE0
`define BMX_PC_RESET      16'h0000
`define BMX_LEN_2         16'h0002
`define BMX_LEN_3         16'h0003
`endif

/* File: shared/bmx_pkg.sv */
package bmx_pkg;
    typedef enum logic [1:0] {
        BMX_FETCH,
        BMX_OPND,
        BMX_EXEC
    } bmx_phase_type;
endpackage

/* File: core/bmx_core.sv */
`timescale 1ns/1ps
`include "bmx_params.svh"
// Overview of operation
// RL1 - increment adds one to the byte, wrapping ff to 00, with no flag change.
// RL2 - branch_on_carry_set is two bytes, two cycles, taken only when carry is one; the core takes three clocks (fetch, operand, execute).
// RL3 - branch_on_carry_set adds the signed second byte to pc plus two, no flag change.
// RL4 - branch_on_bit_clear is three bytes and branches by the third byte when the bit is zero, bit untouched.
// RL5 - branch_on_carry_clear branches by the second byte from pc plus two when carry is zero.
// RL6 - branch_on_acc_nonzero branches from pc plus two when any accumulator bit is one.
// RL7 - branch_on_acc_zero branches from pc plus two when the accumulator is zero, leaving it unchanged.
// RL8 - long_absolute_branch loads pc high from byte two and low from byte three.
// RL9 - byte_copy_op copies source to destination, altering nothing else, over fifteen mode pairs.
// RL10 - direct to direct copy takes source from byte two and destination from byte three.
// RL11 - software must not copy a direct location at the accumulator address into the accumulator.
// RL12 - displacements are signed bytes added to the advanced pc in 16-bit arithmetic.
module bmx_core (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  code_data,
    input  wire logic        carry_in,
    input  wire logic [7:0]  data_rd,
    input  wire logic        bit_rd,
    input  wire logic [1:0]  bank_sel,
    output logic      [15:0] code_addr,
    output logic      [7:0]  data_raddr,
    output logic      [7:0]  data_waddr,
    output logic      [7:0]  data_wdata,
    output logic             data_we,
    output logic      [7:0]  primary_operand_reg,
    output logic             instr_done
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        bmx_pkg::bmx_phase_type phase;
        logic [15:0] pc;
        logic [7:0]  op;
        logic [7:0]  b2;
        logic [1:0]  cnt;
        logic [7:0]  acc;
        logic [15:0] caddr;
        logic [7:0]  raddr;
        logic [7:0]  waddr;
        logic [7:0]  wdata;
        logic        we;
        logic        done;
        logic        deref;
    } bmx_state_type;

    bmx_state_type s_q;
    bmx_state_type s_d;

    logic [7:0]  rn_addr;
    logic [1:0]  len;
    logic [15:0] rel_tgt;
    logic [15:0] next_pc;
    logic        take;
    logic        ind_op;
    logic        two_rd;

    // ************************************************************
    // decode
    // ************************************************************
    always_comb begin
        rn_addr = {3'h0, bank_sel, s_q.op[2:0]};
        len     = 2'h1;
        ind_op  = s_q.op[7:1] == `BMX_OP_INC_IND || s_q.op[7:1] == `BMX_OP_MV_A_IND
            || s_q.op[7:1] == `BMX_OP_MV_DIR_IND || s_q.op[7:1] == `BMX_OP_MV_IND_A
            || s_q.op[7:1] == `BMX_OP_MV_IND_DIR || s_q.op[7:1] == `BMX_OP_MV_IND_IMM;
        two_rd  = s_q.op[7:1] == `BMX_OP_INC_IND || s_q.op[7:1] == `BMX_OP_MV_A_IND
            || s_q.op[7:1] == `BMX_OP_MV_DIR_IND || s_q.op[7:1] == `BMX_OP_MV_IND_DIR;
        if (s_q.op == `BMX_OP_BR_BCLR || s_q.op == `BMX_OP_LJUMP || s_q.op == `BMX_OP_MV_DIR_DIR
            || s_q.op == `BMX_OP_MV_DIR_IMM) begin
            len = 2'h3;
        end else if (s_q.op == `BMX_OP_INC_DIR || s_q.op == `BMX_OP_BR_CSET || s_q.op == `BMX_OP_BR_CCLR
            || s_q.op == `BMX_OP_BR_ANZ || s_q.op == `BMX_OP_BR_AZ || s_q.op == `BMX_OP_MV_A_DIR
            || s_q.op == `BMX_OP_MV_A_IMM || s_q.op[7:3] == `BMX_OP_MV_RN_DIR
            || s_q.op[7:3] == `BMX_OP_MV_RN_IMM || s_q.op == `BMX_OP_MV_DIR_A
            || s_q.op[7:3] == `BMX_OP_MV_DIR_RN || s_q.op[7:1] == `BMX_OP_MV_DIR_IND
            || s_q.op[7:1] == `BMX_OP_MV_IND_DIR || s_q.op[7:1] == `BMX_OP_MV_IND_IMM) begin
            len = 2'h2;
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d      = s_q;
        s_d.we   = 1'b0;
        s_d.done = 1'b0;
        take     = 1'b0;
        next_pc  = s_q.pc + (len == 2'h3 ? `BMX_LEN_3 : (len == 2'h2 ? `BMX_LEN_2 : 16'h0001));
        rel_tgt  = next_pc + {{8{code_data[7]}}, code_data}; // RL12
        unique case (s_q.phase)
            bmx_pkg::BMX_FETCH: begin
                s_d.op    = code_data;
                s_d.cnt   = 2'h1;
                s_d.caddr = s_q.pc + 16'h0001;
                s_d.phase = bmx_pkg::BMX_OPND;
            end
            bmx_pkg::BMX_OPND: begin
                // register or pointer register read, first operand cycle only
                if (s_q.cnt == 2'h1 && !s_q.deref) begin
                    s_d.raddr = rn_addr;
                    if (ind_op) begin
                        s_d.raddr = {3'h0, bank_sel, 2'h0, s_q.op[0]};
                    end
                end
                if (s_q.cnt < len) begin
                    if (s_q.cnt == 2'h1) begin
                        s_d.b2 = code_data;
                        if (s_q.op == `BMX_OP_INC_DIR || s_q.op == `BMX_OP_MV_A_DIR
                            || s_q.op[7:3] == `BMX_OP_MV_RN_DIR || s_q.op == `BMX_OP_MV_DIR_DIR
                            || s_q.op == `BMX_OP_BR_BCLR) begin
                            s_d.raddr = code_data; // RL10
                        end
                    end
                    s_d.cnt   = s_q.cnt + 2'h1;
                    // code_data holds the last operand byte during execute
                    if (s_q.cnt + 2'h1 < len) begin
                        s_d.caddr = s_q.caddr + 16'h0001;
                    end
                end
                if (s_q.cnt + 2'h1 >= len || s_q.cnt == len) begin
                    if (two_rd && !s_q.deref) begin
                        // wait one cycle for the pointer register
                        s_d.deref = 1'b1;
                    end else begin
                        s_d.deref = 1'b0;
                        s_d.phase = bmx_pkg::BMX_EXEC;
                        if (two_rd) begin
                            // pointer now on data_rd
                            s_d.waddr = data_rd;
                            s_d.raddr = s_q.op[7:1] == `BMX_OP_MV_IND_DIR ? s_q.b2 : data_rd; // RL9
                        end
                    end
                end
            end
            bmx_pkg::BMX_EXEC: begin
                s_d.pc    = next_pc;
                s_d.done  = 1'b1;
                s_d.phase = bmx_pkg::BMX_FETCH;
                s_d.waddr = s_q.raddr;
                if (s_q.op == `BMX_OP_INC_A) begin
                    s_d.acc = s_q.acc + 8'h01; // RL1
                end else if (s_q.op == `BMX_OP_INC_DIR || s_q.op[7:3] == `BMX_OP_INC_RN
                    || s_q.op[7:1] == `BMX_OP_INC_IND) begin
                    s_d.wdata = data_rd + 8'h01; // RL1
                    s_d.we    = 1'b1;
                end else if (s_q.op == `BMX_OP_BR_CSET) begin
                    take = carry_in; // RL2 RL3
                end else if (s_q.op == `BMX_OP_BR_CCLR) begin
                    take = ~carry_in; // RL5
                end else if (s_q.op == `BMX_OP_BR_ANZ) begin
                    take = |s_q.acc; // RL6
                end else if (s_q.op == `BMX_OP_BR_AZ) begin
                    take = ~|s_q.acc; // RL7
                end else if (s_q.op == `BMX_OP_BR_BCLR) begin
                    take = ~bit_rd; // RL4
                end else if (s_q.op == `BMX_OP_LJUMP) begin
                    s_d.pc = {s_q.b2, code_data}; // RL8
                end else if (s_q.op[7:3] == `BMX_OP_MV_A_RN || s_q.op == `BMX_OP_MV_A_DIR
                    || s_q.op[7:1] == `BMX_OP_MV_A_IND) begin
                    s_d.acc = data_rd; // RL9 RL11
                end else if (s_q.op == `BMX_OP_MV_A_IMM) begin
                    s_d.acc = s_q.b2; // RL9
                end else if (s_q.op[7:3] == `BMX_OP_MV_RN_A || s_q.op[7:1] == `BMX_OP_MV_IND_A) begin
                    s_d.wdata = s_q.acc; // RL9
                    s_d.we    = 1'b1;
                    s_d.waddr = s_q.op[7:3] == `BMX_OP_MV_RN_A ? rn_addr : data_rd;
                end else if (s_q.op[7:3] == `BMX_OP_MV_RN_DIR || s_q.op[7:3] == `BMX_OP_MV_RN_IMM) begin
                    s_d.wdata = s_q.op[7:3] == `BMX_OP_MV_RN_IMM ? s_q.b2 : data_rd; // RL9
                    s_d.we    = 1'b1;
                    s_d.waddr = rn_addr;
                end else if (s_q.op == `BMX_OP_MV_DIR_A || s_q.op == `BMX_OP_MV_DIR_IMM) begin
                    s_d.wdata = s_q.op == `BMX_OP_MV_DIR_A ? s_q.acc : code_data; // RL9
                    s_d.we    = 1'b1;
                    s_d.waddr = s_q.b2;
                end else if (s_q.op[7:3] == `BMX_OP_MV_DIR_RN || s_q.op[7:1] == `BMX_OP_MV_DIR_IND
                    || s_q.op == `BMX_OP_MV_DIR_DIR) begin
                    s_d.wdata = data_rd; // RL9
                    s_d.we    = 1'b1;
                    s_d.waddr = s_q.op == `BMX_OP_MV_DIR_DIR ? code_data : s_q.b2; // RL10
                end else if (s_q.op[7:1] == `BMX_OP_MV_IND_DIR || s_q.op[7:1] == `BMX_OP_MV_IND_IMM) begin
                    s_d.wdata = s_q.op[7:1] == `BMX_OP_MV_IND_IMM ? s_q.b2 : data_rd; // RL9
                    s_d.we    = 1'b1;
                    s_d.waddr = s_q.op[7:1] == `BMX_OP_MV_IND_IMM ? data_rd : s_q.waddr;
                end
                if (take) begin
                    s_d.pc = rel_tgt; // RL12
                end
                s_d.caddr = s_d.pc;
            end
            default: begin
                s_d.phase = bmx_pkg::BMX_FETCH;
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{phase: bmx_pkg::BMX_FETCH, pc: `BMX_PC_RESET, caddr: `BMX_PC_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign code_addr           = s_q.caddr;
    assign data_raddr          = s_q.raddr;
    assign data_waddr          = s_q.waddr;
    assign data_wdata          = s_q.wdata;
    assign data_we             = s_q.we;
    assign primary_operand_reg = s_q.acc;
    assign instr_done          = s_q.done;

    // ************************************************************
    // checks
    // ************************************************************
    logic [15:0] pc_seen;
    assign pc_seen = s_q.pc;

    carry_branch_a: assert property (@(posedge clk) disable iff (!rst_b) // RL2
        (s_q.phase == bmx_pkg::BMX_EXEC && s_q.op == `BMX_OP_BR_CSET && !carry_in)
        |=> pc_seen == $past(pc_seen) + 16'h0002)
        else $error("carry set branch taken without carry");
    nocarry_branch_a: assert property (@(posedge clk) disable iff (!rst_b) // RL5
        (s_q.phase == bmx_pkg::BMX_EXEC && s_q.op == `BMX_OP_BR_CCLR && carry_in)
        |=> pc_seen == $past(pc_seen) + 16'h0002)
        else $error("carry clear branch taken with carry");
    rel_target_a: assert property (@(posedge clk) disable iff (!rst_b) // RL3 RL12
        (s_q.phase == bmx_pkg::BMX_EXEC && s_q.op == `BMX_OP_BR_CSET && carry_in)
        |=> pc_seen == $past(pc_seen) + 16'h0002 + {{8{$past(code_data[7])}}, $past(code_data)})
        else $error("relative target wrong");
    bit_branch_a: assert property (@(posedge clk) disable iff (!rst_b) // RL4
        (s_q.phase == bmx_pkg::BMX_EXEC && s_q.op == `BMX_OP_BR_BCLR && bit_rd)
        |=> pc_seen == $past(pc_seen) + 16'h0003)
        else $error("bit clear branch wrong");
    acc_nz_a: assert property (@(posedge clk) disable iff (!rst_b) // RL6
        (s_q.phase == bmx_pkg::BMX_EXEC && s_q.op == `BMX_OP_BR_ANZ && s_q.acc == 8'h00)
        |=> pc_seen == $past(pc_seen) + 16'h0002)
        else $error("nonzero branch taken on zero");
    acc_z_a: assert property (@(posedge clk) disable iff (!rst_b) // RL7
        (s_q.phase == bmx_pkg::BMX_EXEC && s_q.op == `BMX_OP_BR_AZ)
        |=> $stable(primary_operand_reg) && !data_we)
        else $error("zero branch changed state");
    long_jump_a: assert property (@(posedge clk) disable iff (!rst_b) // RL8
        (s_q.phase == bmx_pkg::BMX_EXEC && s_q.op == `BMX_OP_LJUMP)
        |=> code_addr == {$past(s_q.b2), $past(code_data)} ##1 instr_done == 1'b0)
        else $error("long jump target wrong");
    inc_wrap_a: assert property (@(posedge clk) disable iff (!rst_b) // RL1
        (s_q.phase == bmx_pkg::BMX_EXEC && s_q.op == `BMX_OP_INC_DIR)
        |=> data_we && data_wdata == $past(data_rd) + 8'h01)
        else $error("increment result wrong");
    dir_copy_a: assert property (@(posedge clk) disable iff (!rst_b) // RL9 RL10
        (s_q.phase == bmx_pkg::BMX_EXEC && s_q.op == `BMX_OP_MV_DIR_DIR)
        |=> data_we && data_waddr == $past(code_data) && data_wdata == $past(data_rd))
        else $error("direct copy wrong");
endmodule // bmx_core

/* File: test/bmx_prog_mem.sv */
`timescale 1ns/1ps
// ************************************************************
// program memory, combinational read
// ************************************************************
module bmx_prog_mem (
    input  wire logic [15:0] code_addr,
    output logic      [7:0]  code_data
);
    logic [7:0] mem [0:65535];

    // unwritten bytes show a pattern that changes with the address
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end

    assign code_data = mem[code_addr];
endmodule // bmx_prog_mem

/* File: test/tb.sv */
`timescale 1ns/1ps
`include "bmx_params.svh"
module tb;
    // ************************************************************
    // signals
    // ************************************************************
    logic        clk;
    logic        rst_b;
    logic [7:0]  code_data;
    logic        carry_in;
    logic [7:0]  data_rd;
    logic        bit_rd;
    logic [1:0]  bank_sel;
    logic [15:0] code_addr;
    logic [7:0]  data_raddr, data_waddr, data_wdata, primary_operand_reg;
    logic        data_we, instr_done, c_v, b_v;
    logic [7:0]  dmem [0:255];
    logic [7:0]  acc_m, a, d, s, v, e, ra, rp, x, w;
    logic [2:0]  r;
    logic [1:0]  bk_v;
    logic [15:0] pc_m, t;
    logic [7:0]  ops [0:4] = '{`BMX_OP_BR_CSET, `BMX_OP_BR_CCLR, `BMX_OP_BR_ANZ, `BMX_OP_BR_AZ, `BMX_OP_BR_BCLR};
    int          n_errors, tests_run, n_wr, seed;

    assign data_rd = dmem[data_raddr];

    bmx_core u_bmx_core (.clk(clk), .rst_b(rst_b), .code_data(code_data), .carry_in(carry_in),
        .data_rd(data_rd), .bit_rd(bit_rd), .bank_sel(bank_sel), .code_addr(code_addr),
        .data_raddr(data_raddr), .data_waddr(data_waddr), .data_wdata(data_wdata), .data_we(data_we),
        .primary_operand_reg(primary_operand_reg), .instr_done(instr_done));
    bmx_prog_mem u_bmx_prog_mem (.code_addr(code_addr), .code_data(code_data));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        carry_in <= c_v;
        bit_rd   <= b_v;
        bank_sel <= bk_v;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task step(input logic [7:0] b0, b1, b2, input logic [15:0] exp_pc, input int exp_wr);
        int cnt;
        u_bmx_prog_mem.mem[code_addr] = b0;
        u_bmx_prog_mem.mem[code_addr + 16'h0001] = b1;
        u_bmx_prog_mem.mem[code_addr + 16'h0002] = b2;
        cnt = 0;
        n_wr = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
            if (data_we === 1'b1) begin
                dmem[data_waddr] = data_wdata;
                n_wr++;
            end
        end while (instr_done !== 1'b1 && cnt < 20);
        check("pc", code_addr, exp_pc);
        check("writes", 16'(n_wr), 16'(exp_wr));
        check("acc", {8'h00, primary_operand_reg}, {8'h00, acc_m});
        pc_m = exp_pc;
    endtask

    function automatic logic [15:0] br_exp(input logic [7:0] op, dsp, acc, input logic c, bt);
        logic [15:0] nx;
        logic        tk;
        nx = pc_m + ((op == `BMX_OP_BR_BCLR) ? `BMX_LEN_3 : `BMX_LEN_2);
        case (op)
            `BMX_OP_BR_CSET: tk = c;
            `BMX_OP_BR_CCLR: tk = ~c;
            `BMX_OP_BR_ANZ:  tk = |acc;
            `BMX_OP_BR_AZ:   tk = ~|acc;
            default:         tk = ~bt;
        endcase
        return tk ? nx + {{8{dsp[7]}}, dsp} : nx;
    endfunction

    task test_done;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        test_done;
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        seed = 32'hf92dbf8e;
        {rst_b, c_v, b_v, bk_v} = '0;
        {n_errors, tests_run, pc_m, acc_m} = '0;
        for (int i = 0; i < 256; i++) dmem[i] = 8'($random(seed));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        acc_m = 8'hFF;
        step(`BMX_OP_MV_A_IMM, 8'hFF, 8'h00, pc_m + `BMX_LEN_2, 0);
        acc_m = 8'h00;
        step(`BMX_OP_INC_A, 8'h00, 8'h00, pc_m + 16'h0001, 0);
        dmem[8'h21] = 8'hFF;
        step(`BMX_OP_INC_DIR, 8'h21, 8'h00, pc_m + `BMX_LEN_2, 1);
        check("inc dir", {8'h00, dmem[8'h21]}, 16'h0000);
        $display("test increment done");
        for (int k = 0; k < 5; k++) begin
            for (int i = 0; i < 8; i++) begin
                a = (i < 2) ? 8'h00 : 8'($random(seed));
                d = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($random(seed));
                acc_m = a;
                step(`BMX_OP_MV_A_IMM, a, 8'h00, pc_m + `BMX_LEN_2, 0);
                c_v = 1'($random(seed));
                b_v = 1'($random(seed));
                t = br_exp(ops[k], d, a, c_v, b_v);
                step(ops[k], (k == 4) ? 8'($random(seed)) : d, (k == 4) ? d : ~d, t, 0);
            end
        end
        $display("test branches done");
        step(`BMX_OP_LJUMP, 8'hFF, 8'hFE, 16'hFFFE, 0);
        acc_m = 8'h5A;
        step(`BMX_OP_MV_A_IMM, 8'h5A, 8'h00, 16'h0000, 0);
        t = 16'($random(seed));
        step(`BMX_OP_LJUMP, t[15:8], t[7:0], t, 0);
        $display("test long branch done");
        for (int i = 0; i < 16; i++) begin
            s = 8'($random(seed)) & 8'h7F;
            d = 8'($random(seed)) & 8'h7F;
            v = 8'($random(seed));
            e = dmem[s];
            step(`BMX_OP_MV_DIR_DIR, s, d, pc_m + `BMX_LEN_3, 1);
            check("dir dest", {8'h00, dmem[d]}, {8'h00, e});
            check("dir src", {8'h00, dmem[s]}, {8'h00, e});
            step(`BMX_OP_MV_DIR_IMM, d, v, pc_m + `BMX_LEN_3, 1);
            check("dir imm", {8'h00, dmem[d]}, {8'h00, v});
            acc_m = dmem[s];
            // source kept below the accumulator address
            step(`BMX_OP_MV_A_DIR, s, 8'h00, pc_m + `BMX_LEN_2, 0);
            step(`BMX_OP_MV_DIR_A, d, 8'h00, pc_m + `BMX_LEN_2, 1);
            check("dir acc", {8'h00, dmem[d]}, {8'h00, acc_m});
        end
        $display("test copies done");
        for (int i = 0; i < 8; i++) begin
            bk_v = 2'($random(seed));
            r    = 3'($random(seed));
            v    = 8'($random(seed));
            w    = 8'($random(seed));
            s    = 8'h20 + (8'($random(seed)) & 8'h1F);
            d    = 8'h40 + (8'($random(seed)) & 8'h1F);
            x    = 8'h60 + (8'($random(seed)) & 8'h1F);
            ra   = {3'h0, bk_v, r};
            rp   = {3'h0, bk_v, 2'h0, r[0]};
            acc_m = v;
            step(`BMX_OP_MV_A_IMM, v, 8'h00, pc_m + `BMX_LEN_2, 0);
            step({`BMX_OP_MV_RN_A, r}, 8'h00, 8'h00, pc_m + 16'h0001, 1);
            step({`BMX_OP_INC_RN, r}, 8'h00, 8'h00, pc_m + 16'h0001, 1);
            check("inc reg", {8'h00, dmem[ra]}, {8'h00, v + 8'h01});
            step({`BMX_OP_MV_RN_IMM, 2'h0, r[0]}, s, 8'h00, pc_m + `BMX_LEN_2, 1);
            check("ptr reg", {8'h00, dmem[rp]}, {8'h00, s});
            step({`BMX_OP_MV_IND_A, r[0]}, 8'h00, 8'h00, pc_m + 16'h0001, 1);
            step({`BMX_OP_INC_IND, r[0]}, 8'h00, 8'h00, pc_m + 16'h0001, 1);
            check("inc ind", {8'h00, dmem[s]}, {8'h00, v + 8'h01});
            acc_m = v + 8'h01;
            step({`BMX_OP_MV_A_IND, r[0]}, 8'h00, 8'h00, pc_m + 16'h0001, 0);
            step({`BMX_OP_MV_IND_IMM, r[0]}, w, 8'h00, pc_m + `BMX_LEN_2, 1);
            step({`BMX_OP_MV_DIR_IND, r[0]}, d, 8'h00, pc_m + `BMX_LEN_2, 1);
            check("dir ind", {8'h00, dmem[d]}, {8'h00, w});
            e = dmem[x];
            step({`BMX_OP_MV_IND_DIR, r[0]}, x, 8'h00, pc_m + `BMX_LEN_2, 1);
            check("ind dir", {8'h00, dmem[s]}, {8'h00, e});
            step({`BMX_OP_MV_RN_DIR, r}, x, 8'h00, pc_m + `BMX_LEN_2, 1);
            step({`BMX_OP_MV_DIR_RN, r}, d, 8'h00, pc_m + `BMX_LEN_2, 1);
            check("reg dir", {8'h00, dmem[d]}, {8'h00, e});
            acc_m = e;
            step({`BMX_OP_MV_A_RN, r}, 8'h00, 8'h00, pc_m + 16'h0001, 0);
        end
        $display("test register and pointer copies done");
        test_done;
    end
endmodule // tb
